// File: pwe_encap_map.svh
`ifndef PWE_ENCAP_MAP_SVH
`define PWE_ENCAP_MAP_SVH
// Control word layout
`define PWE_CW_NIBBLE_ZERO   4'h0
`define PWE_CW_RSVD          12'h000
`define PWE_SEQ_NONE         16'h0000
`define PWE_SEQ_FIRST        16'h0001
`define PWE_SEQ_MAX          16'hffff
`define PWE_SEQ_MSB          15
// Label stack entry layout: label[31:12] tc[11:9] s[8] ttl[7:0]
`define PWE_LBL_MSB          31
`define PWE_LBL_LSB          12
`define PWE_LSE_S_BIT        8
`define PWE_TTL_MSB          7
`define PWE_TTL_ZERO         8'h00
`define PWE_S_ONE            1'b1
`define PWE_TC_ZERO          3'h0
`define PWE_LBL_RSVD_MAX     20'h0000f
`define PWE_LBL_RSVD_OFFSET  20'h00010
`define PWE_MAX_LB_LABELS    3'h3
`define PWE_PW_COUNT         16
`define PWE_PW_IDX_W         4
`define PWE_HASH_INIT        32'h811c9dc5
`define PWE_HASH_MUL_SHIFT   5
`endif

// File: pwe_encap_pkg.sv
package pwe_encap_pkg;
  typedef enum logic [2:0] {
    PWE_IDLE,
    PWE_PUSH_STACK,
    PWE_PUSH_FLOW,
    PWE_PUSH_CW,
    PWE_PAYLOAD
  } pwe_ing_state_t;
  typedef enum logic [1:0] {
    PWE_E_LABELS,
    PWE_E_CW,
    PWE_E_PAYLOAD,
    PWE_E_DROP
  } pwe_egr_state_t;
endpackage

// File: pwe_flow_hash.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwe_encap_map.svh"
// Deterministic flow hash over the MAC pair: same keys always give same label
module pwe_flow_hash
  import pwe_encap_pkg::*;
(
  // Keys
  input  wire logic [47:0] dstMac,
  input  wire logic [47:0] srcMac,
  input  wire logic [3:0]  pwIdx,
  // Result
  output logic      [19:0] flowLabel
);
  logic [31:0] acc;
  logic [19:0] folded;
  // Pure combinational mix, no state, so a flow maps to one label forever
  always_comb begin
    acc = `PWE_HASH_INIT;
    for (int i = 0; i < 6; i++) begin
      acc = acc ^ {24'h000000, dstMac[i*8 +: 8]};
      acc = acc + (acc << `PWE_HASH_MUL_SHIFT);
      acc = acc ^ {24'h000000, srcMac[i*8 +: 8]};
      acc = acc + (acc << `PWE_HASH_MUL_SHIFT);
    end
    acc = acc ^ {28'h0000000, pwIdx};
    folded = acc[19:0] ^ {8'h00, acc[31:20]};
    // Lift out of the reserved range rather than remap, keeps spread even
    if (folded <= `PWE_LBL_RSVD_MAX) begin
      flowLabel = folded + `PWE_LBL_RSVD_OFFSET;
    end else begin
      flowLabel = folded;
    end
  end
endmodule // pwe_flow_hash
`default_nettype wire

// File: pwe_encap_top.sv
// Functional notes
// - Inserted control word starts with a zero nibble.
// - Next twelve control word bits are reserved and sent as zero.
// - Low sixteen control word bits carry a per-pseudo_wire sequence number.
// - Sequence zero means no ordering check; receiver skips it.
// - Flow label is the bottom stack entry, pushed under other labels.
// - Flow label entry has S set and TTL zero.
// - Flow label never lies in reserved range 0..15.
// - Flow label hashed from destination and source MAC.
// - Same flow always receives the same flow label.
// - Flow label generated locally with no negotiation.
// - Egress takes the top stack label as pseudo_wire label then strips flow label unread.
// - Egress strips the control word before Ethernet delivery, keeping only its zero-sequence hint.
// - No flow label load balancing when stack exceeds three labels.
`timescale 1ns/1ps
`default_nettype none
`include "pwe_encap_map.svh"
module pwe_encap_top
  import pwe_encap_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Per pseudo_wire configuration
  input  wire logic [15:0] cwEnable,
  input  wire logic [15:0] flowEnable,
  input  wire logic [15:0] seqEnable,
  // Ingress frame in (32-bit words, MACs given at start)
  input  wire logic        ingValid,
  output logic             ingReady,
  input  wire logic [31:0] ingData,
  input  wire logic        ingSop,
  input  wire logic        ingEop,
  input  wire logic [3:0]  ingPwIdx,
  input  wire logic [47:0] ingDstMac,
  input  wire logic [47:0] ingSrcMac,
  input  wire logic [31:0] ingPwLabel,
  input  wire logic [31:0] ingTunLabel,
  input  wire logic        ingTunPresent,
  input  wire logic [2:0]  ingInLabelCnt,
  // Ingress MPLS out
  output logic             mplsValid,
  input  wire logic        mplsReady,
  output logic [31:0]      mplsData_ff,
  output logic             mplsSop_ff,
  output logic             mplsEop_ff,
  // Egress MPLS in
  input  wire logic        egrValid,
  output logic             egrReady,
  input  wire logic [31:0] egrData,
  input  wire logic        egrSop,
  input  wire logic        egrEop,
  input  wire logic        egrCwPresent,
  // Egress Ethernet out
  output logic             ethValid,
  input  wire logic        ethReady,
  output logic [31:0]      ethData_ff,
  output logic             ethSop_ff,
  output logic             ethEop_ff,
  output logic [19:0]      ethPwLabel_ff,
  output logic             ethSeqCheck_ff
);
  pwe_ing_state_t ingState_ff;
  pwe_ing_state_t nxt_ingState;
  pwe_egr_state_t egrState_ff;
  logic [15:0] seqNum_ff [`PWE_PW_COUNT];
  logic [3:0]  pwIdx_ff;
  logic [19:0] flowLbl_ff;
  logic        useFlow_ff;
  logic        useCw_ff;
  logic        mplsFull_ff;
  logic        ethFull_ff;
  logic [19:0] hashLabel;
  logic        outFree;
  logic        sawPwLabel_ff;
  logic        egrFirst_ff;

  // Label computed locally from the frame keys only
  pwe_flow_hash uHash (
    .dstMac    (ingDstMac),
    .srcMac    (ingSrcMac),
    .pwIdx     (ingPwIdx),
    .flowLabel (hashLabel)
  );

  // One-deep output register; accepts a word when empty or draining
  assign outFree   = !mplsFull_ff || mplsReady;
  assign mplsValid = mplsFull_ff;
  // Input is consumed only in the header-free payload phase
  assign ingReady  = outFree && ((ingState_ff == PWE_IDLE) ? 1'b0 : (ingState_ff == PWE_PAYLOAD));

  // Ingress sequencing: stack, flow label, control word, payload
  always_comb begin
    nxt_ingState = ingState_ff;
    case (ingState_ff)
      PWE_IDLE: begin
        if (ingValid && ingSop) begin
          nxt_ingState = ingTunPresent ? PWE_PUSH_STACK : PWE_PUSH_FLOW;
        end
      end
      PWE_PUSH_STACK: begin
        if (outFree) begin
          nxt_ingState = PWE_PUSH_FLOW;
        end
      end
      PWE_PUSH_FLOW: begin
        // Pseudo_wire label goes out here; flow label follows if enabled
        if (outFree) begin
          nxt_ingState = useFlow_ff ? PWE_PUSH_CW : (useCw_ff ? PWE_PUSH_CW : PWE_PAYLOAD);
        end
      end
      PWE_PUSH_CW: begin
        // Flow-only frames go straight to payload after the flow entry
        if (outFree && (!useFlow_ff || !useCw_ff)) begin
          nxt_ingState = PWE_PAYLOAD;
        end
      end
      PWE_PAYLOAD: begin
        if (outFree && ingValid && ingEop) begin
          nxt_ingState = PWE_IDLE;
        end
      end
      default: nxt_ingState = PWE_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ingState_ff <= PWE_IDLE;
    end else begin
      ingState_ff <= nxt_ingState;
    end
  end

  // Per-frame options latched at start of frame
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pwIdx_ff   <= 4'h0;
      flowLbl_ff <= 20'h00000;
      useFlow_ff <= 1'b0;
      useCw_ff   <= 1'b0;
    end else if (ingState_ff == PWE_IDLE && ingValid && ingSop) begin
      pwIdx_ff   <= ingPwIdx;
      flowLbl_ff <= hashLabel;
      // Deep stacks skip flow labelling entirely
      useFlow_ff <= flowEnable[ingPwIdx] && (ingInLabelCnt <= `PWE_MAX_LB_LABELS);
      useCw_ff   <= cwEnable[ingPwIdx];
    end else if (ingState_ff == PWE_PUSH_CW && outFree && useFlow_ff) begin
      useFlow_ff <= 1'b0; // Flow label just emitted, control word next if enabled
    end
  end

  // Per pseudo_wire sequence counters; zero is skipped on wrap
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `PWE_PW_COUNT; i++) begin
        seqNum_ff[i] <= `PWE_SEQ_FIRST;
      end
    end else if (ingState_ff == PWE_PUSH_CW && outFree && !useFlow_ff && useCw_ff && seqEnable[pwIdx_ff]) begin
      seqNum_ff[pwIdx_ff] <= (seqNum_ff[pwIdx_ff] == `PWE_SEQ_MAX) ? `PWE_SEQ_FIRST : seqNum_ff[pwIdx_ff] + 16'h0001;
    end
  end

  // Output word builder; the stall check keeps data stable under back-pressure
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mplsFull_ff <= 1'b0;
      mplsData_ff <= 32'h00000000;
      mplsSop_ff  <= 1'b0;
      mplsEop_ff  <= 1'b0;
    end else if (outFree) begin
      mplsFull_ff <= 1'b0;
      case (ingState_ff)
        PWE_PUSH_STACK: begin
          mplsFull_ff <= 1'b1;
          mplsData_ff <= {ingTunLabel[`PWE_LBL_MSB:`PWE_LSE_S_BIT+1], 1'b0, ingTunLabel[`PWE_TTL_MSB:0]};
          mplsSop_ff  <= 1'b1;
          mplsEop_ff  <= 1'b0;
        end
        PWE_PUSH_FLOW: begin
          // Pseudo_wire label; bottom only if no flow label below it
          mplsFull_ff <= 1'b1;
          mplsData_ff <= {ingPwLabel[`PWE_LBL_MSB:`PWE_LSE_S_BIT+1], !useFlow_ff, ingPwLabel[`PWE_TTL_MSB:0]};
          mplsSop_ff  <= !ingTunPresent;
          mplsEop_ff  <= 1'b0;
        end
        PWE_PUSH_CW: begin
          mplsFull_ff <= 1'b1;
          mplsSop_ff  <= 1'b0;
          mplsEop_ff  <= 1'b0;
          if (useFlow_ff) begin
            // Flow label as bottom entry with S=1, TTL=0
            mplsData_ff <= {flowLbl_ff, `PWE_TC_ZERO, `PWE_S_ONE, `PWE_TTL_ZERO};
          end else if (seqEnable[pwIdx_ff]) begin
            // Zero nibble, reserved, sequence
            mplsData_ff <= {`PWE_CW_NIBBLE_ZERO, `PWE_CW_RSVD, seqNum_ff[pwIdx_ff]};
          end else begin
            mplsData_ff <= {`PWE_CW_NIBBLE_ZERO, `PWE_CW_RSVD, `PWE_SEQ_NONE};
          end
        end
        PWE_PAYLOAD: begin
          if (ingValid) begin
            mplsFull_ff <= 1'b1;
            mplsData_ff <= ingData;
            mplsSop_ff  <= 1'b0;
            mplsEop_ff  <= ingEop;
          end
        end
        default: mplsFull_ff <= 1'b0;
      endcase
    end
  end

  // Egress: drop labels up to bottom, then control word, then pass payload
  assign ethValid = ethFull_ff;
  assign egrReady = !ethFull_ff || ethReady;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      egrState_ff    <= PWE_E_LABELS;
      sawPwLabel_ff  <= 1'b0;
      ethPwLabel_ff  <= 20'h00000;
      ethSeqCheck_ff <= 1'b0;
    end else if (egrValid && egrReady) begin
      case (egrState_ff)
        PWE_E_LABELS: begin
          // First entry names the pseudo_wire; later ones are dropped unread
          if (egrSop || !sawPwLabel_ff) begin
            ethPwLabel_ff <= egrData[`PWE_LBL_MSB:`PWE_LBL_LSB];
            sawPwLabel_ff <= 1'b1;
          end
          if (egrData[`PWE_LSE_S_BIT]) begin
            egrState_ff <= egrCwPresent ? PWE_E_CW : PWE_E_PAYLOAD;
          end
          if (egrEop) begin
            egrState_ff   <= PWE_E_LABELS;
            sawPwLabel_ff <= 1'b0;
          end
        end
        PWE_E_CW: begin
          // Control word discarded; only its zero-sequence hint is kept
          ethSeqCheck_ff <= (egrData[`PWE_SEQ_MSB:0] != `PWE_SEQ_NONE);
          egrState_ff    <= egrEop ? PWE_E_LABELS : PWE_E_PAYLOAD;
          sawPwLabel_ff  <= !egrEop;
        end
        PWE_E_PAYLOAD: begin
          if (egrEop) begin
            egrState_ff   <= PWE_E_LABELS;
            sawPwLabel_ff <= 1'b0;
          end
        end
        default: egrState_ff <= PWE_E_LABELS;
      endcase
    end
  end

  // First payload word of a frame; a gap in egrValid must not restart the frame
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      egrFirst_ff <= 1'b1;
    end else if (egrValid && egrReady) begin
      egrFirst_ff <= (egrState_ff != PWE_E_PAYLOAD) || egrEop;
    end
  end

  // Ethernet output register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ethFull_ff <= 1'b0;
      ethData_ff <= 32'h00000000;
      ethSop_ff  <= 1'b0;
      ethEop_ff  <= 1'b0;
    end else if (egrReady) begin
      ethFull_ff <= egrValid && (egrState_ff == PWE_E_PAYLOAD);
      if (egrValid && egrState_ff == PWE_E_PAYLOAD) begin
        ethData_ff <= egrData;
        ethEop_ff  <= egrEop;
        ethSop_ff  <= egrFirst_ff;
      end
    end
  end
endmodule // pwe_encap_top
`default_nettype wire

// File: pwe_encap_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pwe_encap_top_asserts (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // Ingress
  input wire logic        ingValid,
  input wire logic        ingReady,
  input wire logic        ingSop,
  input wire logic        ingEop,
  // MPLS legs
  input wire logic        mplsValid,
  input wire logic        mplsReady,
  input wire logic [31:0] mplsData_ff,
  input wire logic        mplsSop_ff,
  input wire logic        egrValid,
  input wire logic        egrReady,
  input wire logic [31:0] egrData,
  input wire logic        egrSop,
  // Ethernet
  input wire logic        ethValid,
  input wire logic        ethReady,
  input wire logic [31:0] ethData_ff,
  input wire logic        ethSop_ff,
  input wire logic [19:0] ethPwLabel_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [19:0] firstLbl_ff;
  // First egress entry, the label the frame must be reported under
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) firstLbl_ff <= 20'h00000;
    else if (egrValid && egrReady && egrSop) firstLbl_ff <= egrData[31:12];
  end
  mpls_hold_a: assert property (mplsValid && !mplsReady |=> mplsValid && $stable(mplsData_ff))
    else $error("stalled mpls word moved");
  eth_hold_a: assert property (ethValid && !ethReady |=> ethValid && $stable(ethData_ff))
    else $error("stalled eth word moved");
  flow_range_a: assert property (mplsValid && mplsData_ff[8] && mplsData_ff[7:0] == 8'h00 |-> mplsData_ff[31:12] > 20'h0000f)
    else $error("flow label in reserved range");
  eop_idle_a: assert property (ingValid && ingReady && ingEop |=> !ingReady)
    else $error("payload taken after end");
  hdr_bound_a: assert property (ingValid && ingSop && !ingReady |-> ##[1:40] ingReady)
    else $error("header phase never ended");
  sop_once_a: assert property (mplsValid && mplsReady && mplsSop_ff |=> !(mplsValid && mplsSop_ff))
    else $error("two starts in a row");
  label_drop_a: assert property (egrValid && egrReady && egrSop && (!ethValid || ethReady) |=> !ethValid)
    else $error("label entry delivered");
  pw_label_a: assert property (ethValid && ethSop_ff |-> ethPwLabel_ff == firstLbl_ff)
    else $error("wrong reported label");
  cover property (mplsValid && mplsReady && mplsData_ff[8] && mplsData_ff[7:0] == 8'h00);
  cover property (mplsValid && !mplsReady);
  cover property (ethValid && ethReady && ethSop_ff);
endmodule // pwe_encap_top_asserts
bind pwe_encap_top pwe_encap_top_asserts pwe_encap_top_asserts_inst (.*);
`default_nettype wire

// File: pwe_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module pwe_core_model (
  // Clock, reset, slow mode
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        stall,
  // From the encapsulator
  input  wire logic        mplsValid,
  output logic             mplsReady,
  input  wire logic [31:0] mplsData_ff,
  input  wire logic        mplsSop_ff,
  input  wire logic        mplsEop_ff,
  // Back to the decapsulator
  output logic             egrValid,
  input  wire logic        egrReady,
  output logic [31:0]      egrData,
  output logic             egrSop,
  output logic             egrEop
);
  logic [31:0] got [$];
  logic [33:0] rep [$];
  logic        tick_ff;
  // Slow mode refuses every other cycle on both legs
  assign mplsReady = !(stall && tick_ff);
  // Words pass on unchanged: paths may hash every label yet alter none
  // nothing past the stack is peeked at and no ordering check is run
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tick_ff <= 1'h0;
      egrValid <= 1'h0;
      {egrSop, egrEop, egrData} <= 34'h0;
    end else begin
      tick_ff <= ~tick_ff;
      if (mplsValid && mplsReady) begin
        got.push_back(mplsData_ff);
        rep.push_back({mplsSop_ff, mplsEop_ff, mplsData_ff});
      end
      if (!egrValid || egrReady) begin
        egrValid <= rep.size() > 0 && !(stall && tick_ff);
        if (rep.size() > 0 && !(stall && tick_ff)) {egrSop, egrEop, egrData} <= rep.pop_front();
        else egrData <= ~egrData;  // Released bus must not echo the old word
      end
    end
  end
endmodule // pwe_core_model
`default_nettype wire

// File: pw_control_word_flow_label_encap_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pw_control_word_flow_label_encap_tb_top;
  logic clock, rst_b, stall, ingValid, ingSop, ingEop, ingTunPresent, mplsReady, egrValid, egrSop, egrEop;
  logic egrCwPresent, ethReady, ingReady, mplsValid, mplsSop_ff, mplsEop_ff, egrReady, ethValid;
  logic ethSop_ff, ethEop_ff, ethSeqCheck_ff;
  logic [15:0] cwEnable, flowEnable, seqEnable, seqNext [16];
  logic [31:0] ingData, ingPwLabel, ingTunLabel, mplsData_ff, egrData, ethData_ff, ethQ [$];
  logic [47:0] ingDstMac, ingSrcMac;
  logic [19:0] ethPwLabel_ff, lastFlow;
  logic [3:0]  ingPwIdx;
  logic [2:0]  ingInLabelCnt;
  logic [1:0]  ethMk [$];
  int          err_total, comparisons;
  pwe_encap_top pwe_encap_top_inst (.*);
  pwe_core_model pwe_core_model_inst (.*);
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  // Eth sink stalls alongside the core model in slow mode
  always @(posedge clock) begin
    if (ethValid && ethReady) begin
      ethQ.push_back(ethData_ff);
      ethMk.push_back({ethSop_ff, ethEop_ff});
    end
    ethReady <= stall ? ~ethReady : 1'h1;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One frame out and back through the core model, judged word by word
  task automatic frame(input logic [3:0] idx, input logic tun, input logic [2:0] cnt);
    int i, k, fp;
    logic tk, fOn, cOn;
    logic [15:0] sq;
    logic [31:0] w [$], g [$];
    fOn = flowEnable[idx] && cnt <= 3'h3;
    cOn = cwEnable[idx];
    sq = seqEnable[idx] ? seqNext[idx] : 16'h0000;
    seqNext[idx] = sq + 16'h0001;
    if (tun) w.push_back(32'h2b000040);
    w.push_back({16'h1a00, idx, 3'h0, !fOn, 8'h40});
    fp = w.size();
    if (fOn) w.push_back(32'h0);
    if (cOn) w.push_back({4'h0, 12'h000, sq});
    for (i = 0; i < 3; i++) w.push_back(32'hc0de0010 + i);
    @(posedge clock);
    {egrCwPresent, ingPwIdx, ingTunPresent, ingInLabelCnt} <= {cOn, idx, tun, cnt};
    ingPwLabel <= {16'h1a00, idx, 12'h040};
    {ingValid, ingSop, ingData} <= {2'h3, 32'hc0de0010};
    i = 0;
    for (k = 0; k < 200 && i < 3; k++) begin
      @(negedge clock);
      tk = ingReady;
      @(posedge clock);
      if (tk) begin
        i++;
        {ingSop, ingEop, ingValid, ingData} <= {1'h0, i == 2, i < 3, 32'hc0de0010 + i};
      end
    end
    for (k = 0; k < 300 && ethQ.size() < 3; k++) @(posedge clock);
    if (k == 300 || i < 3) begin
      err_total++;
      give_verdict();
    end
    g = pwe_core_model_inst.got;
    check("mpls_count", g.size(), w.size());
    foreach (w[j]) if (j != fp || !fOn) check("mpls_word", g[j], w[j]);
    if (fOn) lastFlow = g[fp][31:12];
    if (fOn) check("flow_tail", g[fp][11:0], 12'h100);
    if (fOn) check("flow_range", lastFlow > 20'h0000f, 1'h1);
    check("eth_count", ethQ.size(), 3);
    foreach (ethQ[j]) check("eth_word", ethQ[j], 32'hc0de0010 + j);
    foreach (ethMk[j]) check("eth_marks", ethMk[j], {j == 0, j == 2});
    if (!tun) check("eth_label", ethPwLabel_ff, {16'h1a00, idx});
    if (cOn) check("seq_flag", ethSeqCheck_ff, sq != 16'h0000);
    pwe_core_model_inst.got.delete();
    ethQ.delete();
    ethMk.delete();
  endtask
  // Full encapsulation, stack of exactly three still balanced
  task automatic t_basic;
    frame(4'h3, 1'h0, 3'h3);
    $display("test basic done");
  endtask
  // Same flow again: same label, next sequence
  task automatic t_repeat;
    logic [19:0] f0;
    f0 = lastFlow;
    frame(4'h3, 1'h0, 3'h1);
    check("flow_same", lastFlow, f0);
    $display("test repeat done");
  endtask
  // Deep stack drops the flow entry
  task automatic t_deep;
    frame(4'h3, 1'h0, 3'h4);
    $display("test deep done");
  endtask
  // Tunnel on top, sequencing off, both far ends slow
  task automatic t_tunnel;
    stall <= 1'h1;
    frame(4'h5, 1'h1, 3'h2);
    stall <= 1'h0;
    $display("test tunnel done");
  endtask
  // Control word only, then flow entry only, then neither
  task automatic t_bare;
    frame(4'h9, 1'h0, 3'h0);
    frame(4'ha, 1'h0, 3'h2);
    frame(4'h0, 1'h0, 3'h0);
    $display("test bare done");
  endtask
  initial begin
    {rst_b, stall, ingValid, ingSop, ingEop, ingTunPresent, egrCwPresent} = 7'h00;
    {ingData, ingPwIdx, ingInLabelCnt, ingPwLabel} = 71'h0;
    {ingTunLabel, ingDstMac, ingSrcMac} = {32'h2b000140, 48'h0a0b0c0d0e0f, 48'h020304050607};
    {cwEnable, flowEnable, seqEnable} = {16'h0228, 16'h0428, 16'h0008};
    foreach (seqNext[j]) seqNext[j] = 16'h0001;
    {err_total, comparisons} = 0;
    repeat (2) @(posedge clock);
    rst_b <= 1'h1;
    t_basic();
    t_repeat();
    t_deep();
    t_tunnel();
    t_bare();
    give_verdict();
  end
endmodule // pw_control_word_flow_label_encap_tb_top
`default_nettype wire
